// ===== hdl/rx_stats_pkg.sv
`default_nettype none

// ****************************************************************
// receive statistics increment constants
// ****************************************************************
package rx_stats_pkg;

    // ************************************************************
    // frame length thresholds, in bytes
    // ************************************************************
    localparam int unsigned LEN_W = 16;
    localparam logic [15:0] LEN_MIN_FRAME = 16'h0040;  // 64 bytes, smallest legal frame
    localparam logic [15:0] LEN_CLASS_127 = 16'h007F;  // 127
    localparam logic [15:0] LEN_CLASS_255 = 16'h00FF;  // 255
    localparam logic [15:0] LEN_CLASS_511 = 16'h01FF;  // 511
    localparam logic [15:0] LEN_CLASS_1023 = 16'h03FF; // 1023
    localparam logic [15:0] LEN_CLASS_1518 = 16'h05EE; // 1518
    localparam logic [15:0] LEN_MAX_FRAME = 16'h2580;  // 9600, largest frame still counted as maximum-size

    // ************************************************************
    // destination cast class reported by the receive mac
    // ************************************************************
    typedef enum logic [1:0] {
        CAST_UNICAST   = 2'b00,
        CAST_MULTICAST = 2'b01,
        CAST_BROADCAST = 2'b10,
        CAST_NONE      = 2'b11
    } cast_t;

    // ************************************************************
    // bit positions inside the increment pulse vector
    // ************************************************************
    localparam int unsigned INC_COUNT = 23;
    localparam int unsigned BIT_RUNT = 0;
    localparam int unsigned BIT_SIZE_64 = 1;
    localparam int unsigned BIT_SIZE_127 = 2;
    localparam int unsigned BIT_SIZE_255 = 3;
    localparam int unsigned BIT_SIZE_511 = 4;
    localparam int unsigned BIT_SIZE_1023 = 5;
    localparam int unsigned BIT_SIZE_1518 = 6;
    localparam int unsigned BIT_SIZE_MAX = 7;
    localparam int unsigned BIT_SIZE_OVER = 8;
    localparam int unsigned BIT_MCAST_DATA_ERR = 9;
    localparam int unsigned BIT_MCAST_DATA_GOOD = 10;
    localparam int unsigned BIT_BCAST_DATA_ERR = 11;
    localparam int unsigned BIT_BCAST_DATA_GOOD = 12;
    localparam int unsigned BIT_UCAST_DATA_ERR = 13;
    localparam int unsigned BIT_UCAST_DATA_GOOD = 14;
    localparam int unsigned BIT_MCAST_CTRL = 15;
    localparam int unsigned BIT_BCAST_CTRL = 16;
    localparam int unsigned BIT_UCAST_CTRL = 17;
    localparam int unsigned BIT_PAUSE = 18;
    localparam int unsigned BIT_CHECKSUM_ERR = 19;
    localparam int unsigned BIT_FRAGMENT = 20;
    localparam int unsigned BIT_JABBER = 21;
    localparam int unsigned BIT_SIZE_GOOD_CHECKSUM_BAD = 22;

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [22:0] INC_RESET = 23'h00_0000;
    localparam logic [1:0] RST_SYNC_RESET = 2'h0;

endpackage : rx_stats_pkg

`default_nettype wire

// ===== hdl/inc_pulse_stage.sv
`timescale 1ns/1ns
`default_nettype none

// ****************************************************************
// output register stage for a vector of increment pulses
// ****************************************************************
module inc_pulse_stage #(
    parameter int unsigned WIDTH = 1
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // pulse vector
    input  wire logic [WIDTH-1:0] pulse_next,
    output var  logic [WIDTH-1:0] pulse_reg
);

    // one flop per pulse keeps every top-level output glitch free
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pulse_reg <= '0;
        end else begin
            pulse_reg <= pulse_next;
        end
    end

endmodule // inc_pulse_stage

`default_nettype wire

// ===== hdl/rx_stats_inc.sv
`timescale 1ns/1ns
`default_nettype none

// Overview of operation
// (RULE1) valid non-control broadcast frame gives one-cycle broadcast data good pulse
// (RULE2) errored non-control unicast frame gives one-cycle unicast data error pulse
// (RULE3) valid non-control unicast frame gives one-cycle unicast data good pulse
// (RULE4) valid multicast control frame gives one-cycle multicast control pulse
// (RULE5) valid broadcast control frame gives one-cycle broadcast control pulse
// (RULE6) valid unicast control frame gives one-cycle unicast control pulse
// (RULE7) valid pause frame gives one-cycle pause pulse
// (RULE8) every frame with bad check sequence gives one-cycle checksum error pulse
// (RULE9) checksum pulse follows mac detection, not client stream delivery
// (RULE10) checksum errors counted even when filtering drops the frame
// (RULE11) frame under 64 bytes with crc error gives one-cycle fragment pulse
// (RULE12) oversized frame with crc error gives one-cycle jabber pulse
// (RULE13) legal-size frame with crc error gives one-cycle size-good-checksum-bad pulse
// (RULE14) pulses are driven in every build, counters present or not
// (RULE15) pulses are top outputs and feed counter increment inputs
// (RULE16) all pulses synchronous to receive mac clock, exactly one cycle
// (RULE17) one size-class pulse per legal frame, 64 up to oversized
// (RULE18) runt frame gives one-cycle runt pulse
// (RULE19) multicast and broadcast data good and error pulses mirror unicast ones
// (RULE20) pulses low in reset, at most one per output per frame
module rx_stats_inc
    import rx_stats_pkg::*;
(
    // clock and reset
    input  wire logic             CORE_CLK,
    input  wire logic             RESET_N,
    // frame end report from the receive mac
    input  wire logic             FRAME_DONE,
    input  wire logic [LEN_W-1:0] FRAME_LEN,
    input  wire logic [1:0]       FRAME_CAST,
    input  wire logic             FRAME_IS_CTRL,
    input  wire logic             FRAME_IS_PAUSE,
    input  wire logic             FRAME_CHECKSUM_BAD,
    input  wire logic             FRAME_LINK_ERR,
    // size class increments
    output var  logic             RUNT_PULSE,
    output var  logic             SIZE_64_PULSE,
    output var  logic             SIZE_127_PULSE,
    output var  logic             SIZE_255_PULSE,
    output var  logic             SIZE_511_PULSE,
    output var  logic             SIZE_1023_PULSE,
    output var  logic             SIZE_1518_PULSE,
    output var  logic             SIZE_MAX_PULSE,
    output var  logic             SIZE_OVER_PULSE,
    // data frame increments
    output var  logic             MCAST_DATA_ERR_PULSE,
    output var  logic             MCAST_DATA_GOOD_PULSE,
    output var  logic             BCAST_DATA_ERR_PULSE,
    output var  logic             BCAST_DATA_GOOD_PULSE,
    output var  logic             UCAST_DATA_ERR_PULSE,
    output var  logic             UCAST_DATA_GOOD_PULSE,
    // control frame increments
    output var  logic             MCAST_CTRL_PULSE,
    output var  logic             BCAST_CTRL_PULSE,
    output var  logic             UCAST_CTRL_PULSE,
    output var  logic             PAUSE_PULSE,
    // error increments
    output var  logic             CHECKSUM_ERR_PULSE,
    output var  logic             FRAGMENT_PULSE,
    output var  logic             JABBER_PULSE,
    output var  logic             SIZE_GOOD_CHECKSUM_BAD_PULSE
);

    // ************************************************************
    // reset release
    // ************************************************************
    logic [1:0]           rst_sync_reg;
    logic                 rst_n;
    logic                 done_seen_reg;
    logic                 frame_end;
    logic                 errored;
    logic                 good;
    logic                 is_runt;
    logic                 is_over;
    logic                 is_legal_size;
    cast_t                cast;
    logic                 cast_u;
    logic                 cast_m;
    logic                 cast_b;
    logic [INC_COUNT-1:0] inc_next;
    logic [INC_COUNT-1:0] inc_reg;

    // two flops release reset cleanly; assertion stays asynchronous
    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            rst_sync_reg <= RST_SYNC_RESET;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end

    assign rst_n = rst_sync_reg[1];

    // ************************************************************
    // frame end detection
    // ************************************************************
    // rising edge only, so a strobe held high never counts twice
    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            done_seen_reg <= 1'b0;
        end else begin
            done_seen_reg <= FRAME_DONE;
        end
    end

    assign frame_end = FRAME_DONE && !done_seen_reg; // see (RULE20)

    // ************************************************************
    // frame classification
    // ************************************************************
    // a link error or a bad check sequence both make the frame errored
    assign errored = FRAME_CHECKSUM_BAD || FRAME_LINK_ERR;
    assign good = !errored;
    assign is_runt = FRAME_LEN < LEN_MIN_FRAME;
    assign is_over = FRAME_LEN > LEN_MAX_FRAME;
    assign is_legal_size = !is_runt && !is_over;
    assign cast = cast_t'(FRAME_CAST);

    // reserved cast code falls through to no cast pulse at all
    always_comb begin
        cast_u = 1'b0;
        cast_m = 1'b0;
        cast_b = 1'b0;
        case (cast)
            CAST_UNICAST: begin
                cast_u = 1'b1;
            end
            CAST_MULTICAST: begin
                cast_m = 1'b1;
            end
            CAST_BROADCAST: begin
                cast_b = 1'b1;
            end
            default: begin
                cast_u = 1'b0;
            end
        endcase
    end

    // ************************************************************
    // next pulse vector
    // ************************************************************
    // everything is gated by frame_end, so nothing fires between frames
    always_comb begin
        inc_next = INC_RESET;
        if (frame_end) begin
            // size classes are exclusive: at most one fires per frame
            inc_next[BIT_RUNT] = is_runt; // see (RULE18)
            inc_next[BIT_SIZE_64] = FRAME_LEN == LEN_MIN_FRAME; // see (RULE17)
            inc_next[BIT_SIZE_127] = FRAME_LEN > LEN_MIN_FRAME && FRAME_LEN <= LEN_CLASS_127; // see (RULE17)
            inc_next[BIT_SIZE_255] = FRAME_LEN > LEN_CLASS_127 && FRAME_LEN <= LEN_CLASS_255; // see (RULE17)
            inc_next[BIT_SIZE_511] = FRAME_LEN > LEN_CLASS_255 && FRAME_LEN <= LEN_CLASS_511; // see (RULE17)
            inc_next[BIT_SIZE_1023] = FRAME_LEN > LEN_CLASS_511 && FRAME_LEN <= LEN_CLASS_1023; // see (RULE17)
            inc_next[BIT_SIZE_1518] = FRAME_LEN > LEN_CLASS_1023 && FRAME_LEN <= LEN_CLASS_1518; // see (RULE17)
            inc_next[BIT_SIZE_MAX] = FRAME_LEN > LEN_CLASS_1518 && !is_over; // see (RULE17)
            inc_next[BIT_SIZE_OVER] = is_over; // see (RULE17)
            // data frames, control frames excluded
            inc_next[BIT_MCAST_DATA_ERR] = cast_m && !FRAME_IS_CTRL && errored; // see (RULE19)
            inc_next[BIT_MCAST_DATA_GOOD] = cast_m && !FRAME_IS_CTRL && good; // see (RULE19)
            inc_next[BIT_BCAST_DATA_ERR] = cast_b && !FRAME_IS_CTRL && errored; // see (RULE19)
            inc_next[BIT_BCAST_DATA_GOOD] = cast_b && !FRAME_IS_CTRL && good; // see (RULE1)
            inc_next[BIT_UCAST_DATA_ERR] = cast_u && !FRAME_IS_CTRL && errored; // see (RULE2)
            inc_next[BIT_UCAST_DATA_GOOD] = cast_u && !FRAME_IS_CTRL && good; // see (RULE3)
            // control frames, valid ones only
            inc_next[BIT_MCAST_CTRL] = cast_m && FRAME_IS_CTRL && good; // see (RULE4)
            inc_next[BIT_BCAST_CTRL] = cast_b && FRAME_IS_CTRL && good; // see (RULE5)
            inc_next[BIT_UCAST_CTRL] = cast_u && FRAME_IS_CTRL && good; // see (RULE6)
            inc_next[BIT_PAUSE] = FRAME_IS_PAUSE && good; // see (RULE7)
            // checksum errors ignore any later client-side filtering
            inc_next[BIT_CHECKSUM_ERR] = FRAME_CHECKSUM_BAD; // see (RULE8) (RULE9) (RULE10)
            inc_next[BIT_FRAGMENT] = is_runt && FRAME_CHECKSUM_BAD; // see (RULE11)
            inc_next[BIT_JABBER] = is_over && FRAME_CHECKSUM_BAD; // see (RULE12)
            inc_next[BIT_SIZE_GOOD_CHECKSUM_BAD] = is_legal_size && FRAME_CHECKSUM_BAD; // see (RULE13)
        end
    end

    // ************************************************************
    // output registers
    // ************************************************************
    // one register stage; held at zero while reset is applied
    inc_pulse_stage #(
        .WIDTH      (INC_COUNT)
    ) u_pulse_stage (
        .clk        (CORE_CLK),
        .rst_n      (rst_n),
        .pulse_next (inc_next),
        .pulse_reg  (inc_reg)
    ); // see (RULE16) (RULE20)

    // same flops drive the pins and any counter block, in every build
    assign RUNT_PULSE = inc_reg[BIT_RUNT]; // see (RULE14) (RULE15)
    assign SIZE_64_PULSE = inc_reg[BIT_SIZE_64];
    assign SIZE_127_PULSE = inc_reg[BIT_SIZE_127];
    assign SIZE_255_PULSE = inc_reg[BIT_SIZE_255];
    assign SIZE_511_PULSE = inc_reg[BIT_SIZE_511];
    assign SIZE_1023_PULSE = inc_reg[BIT_SIZE_1023];
    assign SIZE_1518_PULSE = inc_reg[BIT_SIZE_1518];
    assign SIZE_MAX_PULSE = inc_reg[BIT_SIZE_MAX];
    assign SIZE_OVER_PULSE = inc_reg[BIT_SIZE_OVER];
    assign MCAST_DATA_ERR_PULSE = inc_reg[BIT_MCAST_DATA_ERR];
    assign MCAST_DATA_GOOD_PULSE = inc_reg[BIT_MCAST_DATA_GOOD];
    assign BCAST_DATA_ERR_PULSE = inc_reg[BIT_BCAST_DATA_ERR];
    assign BCAST_DATA_GOOD_PULSE = inc_reg[BIT_BCAST_DATA_GOOD];
    assign UCAST_DATA_ERR_PULSE = inc_reg[BIT_UCAST_DATA_ERR];
    assign UCAST_DATA_GOOD_PULSE = inc_reg[BIT_UCAST_DATA_GOOD];
    assign MCAST_CTRL_PULSE = inc_reg[BIT_MCAST_CTRL];
    assign BCAST_CTRL_PULSE = inc_reg[BIT_BCAST_CTRL];
    assign UCAST_CTRL_PULSE = inc_reg[BIT_UCAST_CTRL];
    assign PAUSE_PULSE = inc_reg[BIT_PAUSE];
    assign CHECKSUM_ERR_PULSE = inc_reg[BIT_CHECKSUM_ERR];
    assign FRAGMENT_PULSE = inc_reg[BIT_FRAGMENT];
    assign JABBER_PULSE = inc_reg[BIT_JABBER];
    assign SIZE_GOOD_CHECKSUM_BAD_PULSE = inc_reg[BIT_SIZE_GOOD_CHECKSUM_BAD];

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (!rst_n);

    // a new frame end: strobe rises
    sequence seq_frame_end;
        FRAME_DONE && !done_seen_reg;
    endsequence

    sequence seq_data_frame;
        seq_frame_end ##0 !FRAME_IS_CTRL;
    endsequence

    sequence seq_ctrl_good;
        seq_frame_end ##0 (FRAME_IS_CTRL && !FRAME_CHECKSUM_BAD && !FRAME_LINK_ERR);
    endsequence

    AST_BCAST_DATA_GOOD: assert property ( // see (RULE1)
        (seq_data_frame ##0 (FRAME_CAST == CAST_BROADCAST && !FRAME_CHECKSUM_BAD && !FRAME_LINK_ERR))
        |=> BCAST_DATA_GOOD_PULSE ##1 !BCAST_DATA_GOOD_PULSE)
        else $error("broadcast data good pulse missing or too long");

    AST_UCAST_DATA_ERR: assert property ( // see (RULE2)
        (seq_data_frame ##0 (FRAME_CAST == CAST_UNICAST && (FRAME_CHECKSUM_BAD || FRAME_LINK_ERR)))
        |=> UCAST_DATA_ERR_PULSE && !UCAST_DATA_GOOD_PULSE)
        else $error("unicast data error pulse wrong");

    AST_UCAST_DATA_GOOD_CAUSE: assert property ( // see (RULE3)
        $rose(UCAST_DATA_GOOD_PULSE) |-> $past(frame_end) && !$past(FRAME_IS_CTRL)
        && !$past(FRAME_CHECKSUM_BAD) && !$past(FRAME_LINK_ERR) && $past(FRAME_CAST) == CAST_UNICAST)
        else $error("unicast data good pulse without cause");

    AST_MCAST_CTRL: assert property ( // see (RULE4)
        (seq_ctrl_good ##0 FRAME_CAST == CAST_MULTICAST) |=> MCAST_CTRL_PULSE && !MCAST_DATA_GOOD_PULSE)
        else $error("multicast control pulse missing");

    AST_BCAST_CTRL: assert property ( // see (RULE5)
        (seq_ctrl_good ##0 FRAME_CAST == CAST_BROADCAST) |=> BCAST_CTRL_PULSE)
        else $error("broadcast control pulse missing");

    AST_UCAST_CTRL_ERRORED: assert property ( // see (RULE6)
        UCAST_CTRL_PULSE |-> !$past(FRAME_CHECKSUM_BAD) && !$past(FRAME_LINK_ERR) && $past(FRAME_IS_CTRL))
        else $error("unicast control pulse for errored or data frame");

    AST_PAUSE: assert property ( // see (RULE7)
        (seq_frame_end ##0 (FRAME_IS_PAUSE && !FRAME_CHECKSUM_BAD && !FRAME_LINK_ERR)) |=> PAUSE_PULSE)
        else $error("pause pulse missing");

    AST_CHECKSUM_ERR: assert property ( // see (RULE8)
        CHECKSUM_ERR_PULSE == $past(frame_end && FRAME_CHECKSUM_BAD))
        else $error("checksum error pulse does not follow bad frame");

    AST_FRAGMENT: assert property ( // see (RULE11)
        (seq_frame_end ##0 (FRAME_LEN < LEN_MIN_FRAME && FRAME_CHECKSUM_BAD)) |=> FRAGMENT_PULSE && RUNT_PULSE)
        else $error("fragment pulse missing");

    AST_JABBER: assert property ( // see (RULE12)
        JABBER_PULSE |-> SIZE_OVER_PULSE && CHECKSUM_ERR_PULSE)
        else $error("jabber without oversize and checksum error");

    AST_SIZE_GOOD_BAD: assert property ( // see (RULE13)
        SIZE_GOOD_CHECKSUM_BAD_PULSE |-> CHECKSUM_ERR_PULSE && !RUNT_PULSE && !SIZE_OVER_PULSE)
        else $error("size good checksum bad pulse on illegal size");

    AST_ONE_CYCLE: assert property ( // see (RULE16)
        (|inc_reg) |=> !(|(inc_reg & $past(inc_reg))))
        else $error("increment pulse lasted more than one cycle");

    AST_ONE_SIZE_CLASS: assert property ( // see (RULE17)
        $onehot0(inc_reg[BIT_SIZE_OVER:BIT_RUNT]))
        else $error("more than one size class pulse");

    AST_LEN_1518: assert property ( // see (RULE17)
        (seq_frame_end ##0 FRAME_LEN == LEN_CLASS_1518) |=> SIZE_1518_PULSE && !SIZE_MAX_PULSE)
        else $error("1518 byte frame misclassified");

    AST_MCAST_DATA_ERR: assert property ( // see (RULE19)
        (seq_data_frame ##0 (FRAME_CAST == CAST_MULTICAST && FRAME_LINK_ERR)) |=> MCAST_DATA_ERR_PULSE)
        else $error("multicast data error pulse missing");

    AST_IDLE_QUIET: assert property ( // see (RULE20)
        !frame_end |=> !(|inc_reg))
        else $error("pulse without frame end");

endmodule // rx_stats_inc

`default_nettype wire

// ===== bench/stats_count_model.sv
`timescale 1ns/1ns
`default_nettype none

// ****************************************************************
// counter bank standing in for the statistics registers
// ****************************************************************
module stats_count_model
    import rx_stats_pkg::*;
(
    // clock and reset
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    // increment pulses from the block
    input  wire logic [INC_COUNT-1:0] inc,
    // running totals
    output var  logic [15:0]          count_reg [INC_COUNT]
);
    // one counter per pulse; a pulse held two cycles is counted twice, so stretching shows in the totals
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < INC_COUNT; i++) begin
                count_reg[i] <= 16'h0000;
            end
        end else begin
            for (int i = 0; i < INC_COUNT; i++) begin
                if (inc[i]) begin
                    count_reg[i] <= count_reg[i] + 16'h0001;
                end
            end
        end
    end
endmodule // stats_count_model

`default_nettype wire

// ===== bench/tb_top.sv
`timescale 1ns/1ns
`default_nettype none

module tb_top
    import rx_stats_pkg::*;
;
    logic                 CORE_CLK = 1'b0;
    logic                 RESET_N = 1'b0;
    logic                 FRAME_DONE = 1'b0;
    logic [LEN_W-1:0]     FRAME_LEN = 16'h0000;
    logic [1:0]           FRAME_CAST = 2'h0;
    logic                 FRAME_IS_CTRL = 1'b0;
    logic                 FRAME_IS_PAUSE = 1'b0;
    logic                 FRAME_CHECKSUM_BAD = 1'b0;
    logic                 FRAME_LINK_ERR = 1'b0;
    wire  logic [INC_COUNT-1:0] inc;
    logic [15:0]          count [INC_COUNT];
    logic [15:0]          exp_count [INC_COUNT];
    int                   num_errors = 0;
    int                   comparisons = 0;
    logic [15:0]          corner_len [17] = '{16'h0000, 16'h003F, 16'h0040, 16'h0041, 16'h007F, 16'h0080,
        16'h00FF, 16'h0100, 16'h01FF, 16'h0200, 16'h03FF, 16'h0400, 16'h05EE, 16'h05EF, 16'h2580, 16'h2581, 16'hFFFF};

    // 250 MHz core clock
    always #2 CORE_CLK = ~CORE_CLK;

    rx_stats_inc dut (
        .CORE_CLK(CORE_CLK), .RESET_N(RESET_N), .FRAME_DONE(FRAME_DONE), .FRAME_LEN(FRAME_LEN),
        .FRAME_CAST(FRAME_CAST), .FRAME_IS_CTRL(FRAME_IS_CTRL), .FRAME_IS_PAUSE(FRAME_IS_PAUSE),
        .FRAME_CHECKSUM_BAD(FRAME_CHECKSUM_BAD), .FRAME_LINK_ERR(FRAME_LINK_ERR),
        .RUNT_PULSE(inc[BIT_RUNT]), .SIZE_64_PULSE(inc[BIT_SIZE_64]), .SIZE_127_PULSE(inc[BIT_SIZE_127]),
        .SIZE_255_PULSE(inc[BIT_SIZE_255]), .SIZE_511_PULSE(inc[BIT_SIZE_511]),
        .SIZE_1023_PULSE(inc[BIT_SIZE_1023]), .SIZE_1518_PULSE(inc[BIT_SIZE_1518]),
        .SIZE_MAX_PULSE(inc[BIT_SIZE_MAX]), .SIZE_OVER_PULSE(inc[BIT_SIZE_OVER]),
        .MCAST_DATA_ERR_PULSE(inc[BIT_MCAST_DATA_ERR]), .MCAST_DATA_GOOD_PULSE(inc[BIT_MCAST_DATA_GOOD]),
        .BCAST_DATA_ERR_PULSE(inc[BIT_BCAST_DATA_ERR]), .BCAST_DATA_GOOD_PULSE(inc[BIT_BCAST_DATA_GOOD]),
        .UCAST_DATA_ERR_PULSE(inc[BIT_UCAST_DATA_ERR]), .UCAST_DATA_GOOD_PULSE(inc[BIT_UCAST_DATA_GOOD]),
        .MCAST_CTRL_PULSE(inc[BIT_MCAST_CTRL]), .BCAST_CTRL_PULSE(inc[BIT_BCAST_CTRL]),
        .UCAST_CTRL_PULSE(inc[BIT_UCAST_CTRL]), .PAUSE_PULSE(inc[BIT_PAUSE]),
        .CHECKSUM_ERR_PULSE(inc[BIT_CHECKSUM_ERR]), .FRAGMENT_PULSE(inc[BIT_FRAGMENT]),
        .JABBER_PULSE(inc[BIT_JABBER]), .SIZE_GOOD_CHECKSUM_BAD_PULSE(inc[BIT_SIZE_GOOD_CHECKSUM_BAD])
    );

    stats_count_model partner (.clk(CORE_CLK), .rst_n(RESET_N), .inc(inc), .count_reg(count));

    // pulse pattern expected for one frame report
    function automatic logic [INC_COUNT-1:0] expect_inc(logic [15:0] len, logic [1:0] cast, logic ctl,
                                                       logic pau, logic bad, logic lerr);
        logic [INC_COUNT-1:0] e;
        logic                 err;
        e = INC_RESET;
        err = bad | lerr;
        if (len < LEN_MIN_FRAME) e[BIT_RUNT] = 1'b1;
        else if (len == LEN_MIN_FRAME) e[BIT_SIZE_64] = 1'b1;
        else if (len <= LEN_CLASS_127) e[BIT_SIZE_127] = 1'b1;
        else if (len <= LEN_CLASS_255) e[BIT_SIZE_255] = 1'b1;
        else if (len <= LEN_CLASS_511) e[BIT_SIZE_511] = 1'b1;
        else if (len <= LEN_CLASS_1023) e[BIT_SIZE_1023] = 1'b1;
        else if (len <= LEN_CLASS_1518) e[BIT_SIZE_1518] = 1'b1;
        else if (len <= LEN_MAX_FRAME) e[BIT_SIZE_MAX] = 1'b1;
        else e[BIT_SIZE_OVER] = 1'b1;
        // errored control frames count nowhere by cast
        case (cast)
            CAST_UNICAST: e[ctl ? BIT_UCAST_CTRL : (err ? BIT_UCAST_DATA_ERR : BIT_UCAST_DATA_GOOD)] = !(ctl && err);
            CAST_MULTICAST: e[ctl ? BIT_MCAST_CTRL : (err ? BIT_MCAST_DATA_ERR : BIT_MCAST_DATA_GOOD)] = !(ctl && err);
            CAST_BROADCAST: e[ctl ? BIT_BCAST_CTRL : (err ? BIT_BCAST_DATA_ERR : BIT_BCAST_DATA_GOOD)] = !(ctl && err);
            default: ;
        endcase
        e[BIT_PAUSE] = pau & !err;
        e[BIT_CHECKSUM_ERR] = bad;
        e[BIT_FRAGMENT] = bad && (len < LEN_MIN_FRAME);
        e[BIT_JABBER] = bad && (len > LEN_MAX_FRAME);
        e[BIT_SIZE_GOOD_CHECKSUM_BAD] = bad && (len >= LEN_MIN_FRAME) && (len <= LEN_MAX_FRAME);
        return e;
    endfunction

    task automatic check(string what, logic [INC_COUNT-1:0] exp, logic [INC_COUNT-1:0] got);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one frame report; strobe held for hold extra cycles, fields scrambled once released
    task automatic send(logic [15:0] len, logic [1:0] cast, logic ctl, logic pau, logic bad, logic lerr, int hold);
        logic [INC_COUNT-1:0] e;
        e = expect_inc(len, cast, ctl, pau, bad, lerr);
        FRAME_DONE = 1'b1;
        FRAME_LEN = len;
        FRAME_CAST = cast;
        FRAME_IS_CTRL = ctl;
        FRAME_IS_PAUSE = pau;
        FRAME_CHECKSUM_BAD = bad;
        FRAME_LINK_ERR = lerr;
        @(posedge CORE_CLK);
        #1;
        check("frame pulses", e, inc);
        repeat (hold) begin
            @(posedge CORE_CLK);
            #1;
            check("held strobe", INC_RESET, inc);
        end
        FRAME_DONE = 1'b0;
        {FRAME_LEN, FRAME_CAST, FRAME_IS_CTRL, FRAME_IS_PAUSE, FRAME_CHECKSUM_BAD, FRAME_LINK_ERR} = 22'($urandom);
        @(posedge CORE_CLK);
        #1;
        check("pulse width", INC_RESET, inc);
        for (int i = 0; i < INC_COUNT; i++) exp_count[i] = exp_count[i] + 16'(e[i]);
    endtask

    task automatic check_counts();
        for (int i = 0; i < INC_COUNT; i++) begin
            comparisons++;
            if (count[i] !== exp_count[i]) begin
                num_errors++;
                $display("MISMATCH count %0d expected %0d seen %0d", i, exp_count[i], count[i]);
            end
        end
    endtask

    task automatic do_reset(int cycles);
        RESET_N = 1'b0;
        repeat (cycles) @(posedge CORE_CLK);
        #1;
        RESET_N = 1'b1;
        for (int i = 0; i < INC_COUNT; i++) exp_count[i] = 16'h0000;
        repeat (4) @(posedge CORE_CLK);
        #1;
    endtask

    task automatic results();
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // watchdog, about eighteen times the expected run
    initial begin
        repeat (20000) @(posedge CORE_CLK);
        num_errors++;
        $display("MISMATCH watchdog expected finish seen timeout");
        results();
    end

    initial begin
        void'($urandom(7));
        do_reset(12);
        // every size boundary, good and bad check sequence
        foreach (corner_len[i]) for (int b = 0; b < 2; b++)
            send(corner_len[i], 2'($urandom), 1'($urandom), 1'b0, b[0], 1'b0, 0);
        $display("test size_classes done");
        // every cast against every control, error and link error mix, pause set only on control frames
        for (int c = 0; c < 4; c++) for (int f = 0; f < 16; f++)
            send(16'h0100 + 16'($urandom_range(0, 1000)), 2'(c), f[0], f[0] & f[1], f[2], f[3], 0);
        // in the cast_flags sweep above
        $display("test cast_flags done");
        // random back-to-back frames, some with a stretched strobe
        for (int n = 0; n < 300; n++)
            send(16'($urandom_range(0, 12000)), 2'($urandom), n[0], n[1], 1'($urandom), 1'($urandom),
                 int'($urandom_range(0, 2)));
        check_counts();
        $display("test random_frames done");
        // frame report arriving while reset is held
        RESET_N = 1'b0;
        FRAME_DONE = 1'b1;
        repeat (2) begin
            @(posedge CORE_CLK);
            #1;
            check("in reset", INC_RESET, inc);
        end
        FRAME_DONE = 1'b0;
        do_reset(1);
        send(16'h0028, 2'h0, 1'b0, 1'b0, 1'b1, 1'b0, 0);
        check_counts();
        $display("test mid_reset done");
        results();
    end
endmodule // tb_top

`default_nettype wire
